// >>> pkg/lhp_map.svh
`ifndef LHP_MAP_SVH
`define LHP_MAP_SVH

// ----------------------------------------------------------------------------
// Host parallel port constants
// ----------------------------------------------------------------------------

// Address and data bus widths of the parallel port.
`define LHP_ADDR_W      8
`define LHP_DATA_W      8

// Number of timing ticks an access waits before it completes.
`define LHP_ACC_TICKS   2

// Reset value of every register byte and of the read data latch.
`define LHP_RST_BYTE    8'h00

// Field positions of the packed host request word.
`define LHP_REQ_CSN_BIT 18
`define LHP_REQ_WRN_BIT 17
`define LHP_REQ_RDN_BIT 16

`endif

// >>> pkg/lhp_pkg.sv
// ----------------------------------------------------------------------------
// Host parallel port types
// ----------------------------------------------------------------------------
package lhp_pkg;

    // Pins of one host access; strobes and select are active low.
    typedef struct packed {
        logic       cs_n;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lhp_req_s;

    // Access sequencer states, one-hot.
    typedef enum logic [2:0] {
        LHP_IDLE = 3'b001,
        LHP_WAIT = 3'b010,
        LHP_DONE = 3'b100
    } lhp_state_e;

endpackage

// >>> core/lhp_regfile.sv
`timescale 1ns/1ps
`include "lhp_map.svh"

// ----------------------------------------------------------------------------
// Byte-wide register space with one host port and one core read port
// ----------------------------------------------------------------------------
module lhp_regfile #(
    parameter int ADDR_W = `LHP_ADDR_W,
    parameter int DATA_W = `LHP_DATA_W
) (
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic [ADDR_W-1:0] core_raddr_i,
    output logic      [DATA_W-1:0] core_rdata_o
);
    import lhp_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] mem_r   [DEPTH];
    logic [DATA_W-1:0] mem_nxt [DEPTH];
    logic [DATA_W-1:0] core_rdata_r;
    logic [DATA_W-1:0] core_rdata_nxt;

    // Next contents: only the addressed byte changes on a write.
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (we_i) begin
            mem_nxt[addr_i] = wdata_i;
        end
        core_rdata_nxt = mem_r[core_raddr_i];
    end

    // Storage is plain flip-flops so every byte has a defined reset value.
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= `LHP_RST_BYTE;
            end
            core_rdata_r <= `LHP_RST_BYTE;
        end else begin
            mem_r        <= mem_nxt;
            core_rdata_r <= core_rdata_nxt;
        end
    end

    // The host side is captured by the sequencer, so a plain mux suffices here.
    assign rdata_o      = mem_r[addr_i];
    assign core_rdata_o = core_rdata_r;

endmodule // lhp_regfile

// >>> core/lhp_port.sv
`timescale 1ns/1ps
`include "lhp_map.svh"

// ----------------------------------------------------------------------------
// Host parallel port
// ----------------------------------------------------------------------------

module lhp_port #(
    parameter int ADDR_W    = `LHP_ADDR_W,
    parameter int DATA_W    = `LHP_DATA_W,
    parameter int ACC_TICKS = `LHP_ACC_TICKS
) (
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire logic              mode_sync_i,
    input  wire logic              port_clk_i,
    input  wire lhp_pkg::lhp_req_s host_req_i,
    output logic                   rdy_n_o,
    output logic      [DATA_W-1:0] data_o,
    output logic                   data_oe_o,
    input  wire logic [ADDR_W-1:0] core_raddr_i,
    output logic      [DATA_W-1:0] core_rdata_o
);
    import lhp_pkg::*;

    localparam int CNT_W   = $clog2(ACC_TICKS + 1);
    localparam int RDY_LAT = ACC_TICKS + 1;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    lhp_state_e        state_r;
    lhp_state_e        state_nxt;
    logic [CNT_W-1:0]  tick_cnt_r;
    logic [CNT_W-1:0]  tick_cnt_nxt;
    logic              is_read_r;
    logic              is_read_nxt;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic              port_clk_q_r;
    logic              port_clk_q_nxt;
    logic              tick;
    logic              start;
    logic              held;
    logic              last_tick;
    logic              reg_we;
    logic [DATA_W-1:0] reg_rdata;

    // One strobe alone under chip select is a legal access request.
    function automatic logic req_valid(input lhp_req_s r);
        req_valid = !r.cs_n && (r.wr_n ^ r.rd_n);
    endfunction

    // ------------------------------------------------------------------------
    // Timing reference
    // ------------------------------------------------------------------------

    // The port clock is sampled as an ordinary input and its rising edge is a
    // tick; in asynchronous mode every core cycle is a tick. The core clock
    // must run well above the port clock or port clock edges will be missed.
    always_comb begin
        port_clk_q_nxt = port_clk_i;
        if (mode_sync_i) begin
            tick = port_clk_i && !port_clk_q_r;
        end else begin
            tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            port_clk_q_r <= 1'b0;
        end else begin
            port_clk_q_r <= port_clk_q_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------------

    // Requests with both strobes low are ignored rather than guessed at.
    assign start     = req_valid(host_req_i);
    assign last_tick = tick && (tick_cnt_r == CNT_W'(ACC_TICKS - 1));

    // The access must keep its original direction until it ends.
    always_comb begin
        held = start && (is_read_r == !host_req_i.rd_n);
    end

    // Next state, tick count, direction and read latch.
    always_comb begin
        state_nxt    = state_r;
        tick_cnt_nxt = tick_cnt_r;
        is_read_nxt  = is_read_r;
        rd_data_nxt  = rd_data_r;
        reg_we       = 1'b0;
        unique case (state_r)
            LHP_IDLE: begin
                tick_cnt_nxt = '0;
                if (start) begin
                    state_nxt   = LHP_WAIT;
                    is_read_nxt = !host_req_i.rd_n;
                end
            end
            LHP_WAIT: begin
                if (!held) begin
                    // Released early: the access is dropped with no effect.
                    state_nxt = LHP_IDLE;
                end else if (last_tick) begin
                    state_nxt = LHP_DONE;
                    if (is_read_r) begin
                        rd_data_nxt = reg_rdata;
                    end else begin
                        reg_we = 1'b1;
                    end
                end else if (tick) begin
                    tick_cnt_nxt = tick_cnt_r + CNT_W'(1);
                end
            end
            LHP_DONE: begin
                // Ready stands until the host ends the access.
                if (!held) begin
                    state_nxt = LHP_IDLE;
                end
            end
            default: begin
                state_nxt = LHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_r    <= LHP_IDLE;
            tick_cnt_r <= '0;
            is_read_r  <= 1'b0;
            rd_data_r  <= `LHP_RST_BYTE;
        end else begin
            state_r    <= state_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            is_read_r  <= is_read_nxt;
            rd_data_r  <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------------

    // Ready and the bus enable are decoded straight from the pins and state,
    // so the bus floats in the same cycle the host lets go of it.
    assign rdy_n_o   = !(state_r == LHP_DONE);
    assign data_oe_o = !host_req_i.cs_n && !host_req_i.rd_n
                       && host_req_i.wr_n;
    assign data_o    = rd_data_r;

    // ------------------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------------------
    lhp_regfile #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_regfile (
        .core_clk_i   (core_clk_i),
        .srst_i       (srst_i),
        .we_i         (reg_we),
        .addr_i       (host_req_i.addr),
        .wdata_i      (host_req_i.wdata),
        .rdata_o      (reg_rdata),
        .core_raddr_i (core_raddr_i),
        .core_rdata_o (core_rdata_o)
    );

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_async_start;
        state_r == LHP_IDLE && start && !mode_sync_i;
    endsequence

    sequence s_ready_or_drop;
        !rdy_n_o || state_r == LHP_IDLE;
    endsequence

    // Port clock paces the wait: no port clock edge, no progress.
    a_sync_pace_hold: assert property (
        (state_r == LHP_WAIT && held && mode_sync_i && !tick)
        |=> state_r == LHP_WAIT && $stable(tick_cnt_r))
        else $error("sync access advanced without a port clock edge");

    // Internal clock completes an async access in a fixed number of cycles.
    a_async_ready_time: assert property (
        s_async_start |-> ##[1:RDY_LAT] s_ready_or_drop)
        else $error("async access did not complete in time");

    // Deselected bus returns the port to idle with no write.
    a_idle_deselect: assert property (
        host_req_i.cs_n |=> state_r == LHP_IDLE && !reg_we)
        else $error("port active while chip select high");

    // Written byte lands at the addressed register.
    // The host has usually moved on by the next edge, so look at the stored byte.
    a_write_stores: assert property (
        reg_we |=> u_regfile.mem_r[$past(host_req_i.addr)] == $past(host_req_i.wdata))
        else $error("write data not stored at address");

    // Read latch holds the addressed byte when ready appears.
    a_read_returns: assert property (
        ($rose(!rdy_n_o) && is_read_r) |-> rd_data_r == $past(reg_rdata))
        else $error("read data does not match register");

    // Ready holds while the host keeps the strobe, and drops after release.
    a_ready_holds: assert property (
        (!rdy_n_o && held) |=> !rdy_n_o)
        else $error("ready dropped while access still held");

    a_ready_release: assert property (
        (!rdy_n_o && !start) |=> rdy_n_o && state_r == LHP_IDLE)
        else $error("ready stayed after strobe release");

    // Device never drives the bus during a write.
    a_no_drive_write: assert property (
        !host_req_i.wr_n |-> !data_oe_o)
        else $error("data driven during a write");

    // Bus floats whenever select or read strobe is high.
    a_float_idle: assert property (
        (host_req_i.cs_n || host_req_i.rd_n) |-> !data_oe_o)
        else $error("data driven outside a read");

endmodule // lhp_port

// >>> verification/lhp_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host side of the parallel port
// ----------------------------------------------------------------------------
module lhp_host_model (
    input  wire logic              core_clk_i,
    input  wire logic              rdy_n_i,
    input  wire logic [7:0]        data_i,
    input  wire logic              data_oe_i,
    output lhp_pkg::lhp_req_s      req_o
);
    import lhp_pkg::*;

    // The bus starts idle, with select and both strobes high.
    initial begin
        req_o = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
    end

    // One access; lat is -1 when ready never came within max_cyc edges.
    task automatic access(input bit cs, input bit wr, input bit rd, input logic [7:0] a,
                          input logic [7:0] d, input int max_cyc, output logic [7:0] q,
                          output int lat, output logic oe);
        int n;
        n = 0;
        lat = -1;
        q = 8'h00;
        oe = 1'b0;
        @(negedge core_clk_i);
        req_o.cs_n = !cs;
        req_o.wr_n = !wr;
        req_o.rd_n = !rd;
        req_o.addr = a;
        req_o.wdata = d;
        // Everything holds until ready is seen low at a rising edge or max_cyc edges have passed.
        while (lat < 0 && n < max_cyc) begin
            @(posedge core_clk_i);
            n++;
            #1;
            oe = data_oe_i;
            if (rdy_n_i === 1'b0) begin
                lat = n;
                q = data_i;
            end
        end
        // A released host leaves inverted values so stale bytes never pass for data.
        @(negedge core_clk_i);
        req_o = '{1'b1, 1'b1, 1'b1, ~a, ~d};
        @(posedge core_clk_i);
        #1;
    endtask
endmodule // lhp_host_model

// >>> verification/tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Bench for the host parallel port
// ----------------------------------------------------------------------------
module tb;
    import lhp_pkg::*;

    localparam int ACC = 2;

    logic              core_clk;
    logic              srst;
    logic              mode_sync;
    logic              port_clk;
    logic              pclk_run;
    lhp_req_s          host_req;
    logic              rdy_n;
    logic [7:0]        data;
    logic              data_oe;
    logic [7:0]        core_raddr;
    logic [7:0]        core_rdata;
    int                mem [256];
    int                n_errors;
    int                num_checks;
    int                pdiv;

    lhp_port #(.ACC_TICKS(ACC)) u_lhp_port (
        .core_clk_i(core_clk), .srst_i(srst), .mode_sync_i(mode_sync),
        .port_clk_i(port_clk), .host_req_i(host_req), .rdy_n_o(rdy_n), .data_o(data),
        .data_oe_o(data_oe), .core_raddr_i(core_raddr), .core_rdata_o(core_rdata));

    lhp_host_model u_host_model (
        .core_clk_i(core_clk), .rdy_n_i(rdy_n), .data_i(data), .data_oe_i(data_oe),
        .req_o(host_req));

    // Core clock at 25 MHz.
    always #20 core_clk = ~core_clk;

    // Port clock runs six core cycles a period, well under half the core rate.
    always @(negedge core_clk) begin
        if (pclk_run) begin
            pdiv = (pdiv + 1) % 3;
            if (pdiv == 0) port_clk = !port_clk;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // A whole access, checked against the byte model; exp_lat 0 means port clock timing.
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [7:0] d,
                        input int exp_lat);
        logic [7:0] q;
        int lat;
        logic oe;
        u_host_model.access(1'b1, wr, !wr, a, d, 200, q, lat, oe);
        if (exp_lat > 0) chk("async latency", exp_lat, lat);
        else chk("sync latency", 1, lat > ACC + 1 && lat <= 6 * ACC + 2);
        if (wr) mem[a] = d;
        if (!wr) chk("read data", mem[a], q);
        chk("drive only on read", !wr, oe);
        chk("ready after release", 1, rdy_n);
        chk("bus after release", 0, data_oe);
    endtask

    // An access that must not complete and must leave the byte untouched.
    task automatic refused(input bit cs, input bit wr, input bit rd, input logic [7:0] a,
                           input int maxc);
        logic [7:0] q;
        int lat;
        logic oe;
        u_host_model.access(cs, wr, rd, a, ~8'(mem[a]), maxc, q, lat, oe);
        chk("no ready", 32'hffffffff, lat);
        // The check read needs the port clock running in synchronous mode.
        if (mode_sync) pclk_run = 1'b1;
        xfer(1'b0, a, 8'h00, mode_sync ? 0 : ACC + 1);
    endtask

    task automatic core_peek(input logic [7:0] a);
        @(negedge core_clk);
        core_raddr = a;
        @(posedge core_clk);
        #1;
        chk("core read", mem[a], core_rdata);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        core_clk = 1'b0;
        srst = 1'b1;
        mode_sync = 1'b0;
        port_clk = 1'b0;
        pclk_run = 1'b0;
        core_raddr = 8'h00;
        pdiv = 0;
        n_errors = 0;
        num_checks = 0;
        foreach (mem[i]) mem[i] = 0;
        void'($urandom(32'haf68));
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        chk("reset ready", 1, rdy_n);
        chk("reset data", 0, data);
        $display("test reset done");
        // Internal timing with the port clock held still; both end addresses first.
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            d = 8'($urandom);
            xfer(1'b1, a, d, ACC + 1);
            xfer(1'b0, a, 8'h00, ACC + 1);
            core_peek(a);
        end
        xfer(1'b0, 8'($urandom), 8'h00, ACC + 1);
        $display("test async done");
        // Idle select, both strobes low, and a write dropped before ready.
        a = 8'($urandom);
        refused(1'b0, 1'b1, 1'b0, a, 8);
        refused(1'b1, 1'b1, 1'b1, a, 8);
        refused(1'b1, 1'b1, 1'b0, a, ACC);
        $display("test refusals done");
        // Host clock timing: nothing completes while the port clock stands still.
        @(negedge core_clk);
        mode_sync = 1'b1;
        refused(1'b1, 1'b1, 1'b0, a, 20);
        pclk_run = 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            xfer(1'b1, a, 8'($urandom), 0);
            xfer(1'b0, a, 8'h00, 0);
        end
        $display("test sync done");
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #(40 * 20000);
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule // tb
